/* File: core/rcr_defines.svh */
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

`define RCR_ADDR_STATUS      12'h000
`define RCR_ADDR_PCON        12'h004
`define RCR_ADDR_CTRL        12'h008
`define RCR_ADDR_PC          12'h00c
`define RCR_ADDR_EVT_STAT    12'h010
`define RCR_ADDR_EVT_EN      12'h014
`define RCR_ADDR_EVT_CLR     12'h018

// Core status field: bit 4 timeout, bit 3 power-down, bits 2:0 arithmetic
`define RCR_ST_TO            4
`define RCR_ST_PD            3
`define RCR_ST_POR_VAL       5'h18

// Power control field positions
`define RCR_PC_STACK_OVERFLOW_FLAG        7
`define RCR_PC_STACK_UNDERFLOW_FLAG        6
`define RCR_PC_WINV          5
`define RCR_PC_WDT           4
`define RCR_PC_PIN           3
`define RCR_PC_INSTR         2
`define RCR_PC_PWRON         1
`define RCR_PC_BROWN         0
`define RCR_PC_IMPL_MASK     8'hff
`define RCR_PC_POR_VAL       8'h1c
`define RCR_PC_WR_MASK       8'hff

`define RCR_CTRL_STACK_ERROR_RESET_ENABLE      0
`define RCR_CTRL_GIE         1

`define RCR_RESET_VECTOR     16'h0000
`define RCR_INT_VECTOR       16'h0004

`define RCR_EVT_W            11

`endif

/* File: core/rcr_pkg.sv */
package rcr_pkg;
	typedef enum logic [3:0] {
		RCR_EV_NONE   = 4'b0000,
		RCR_EV_POR    = 4'b0001,
		RCR_EV_BOR    = 4'b0010,
		RCR_EV_WDT    = 4'b0011,
		RCR_EV_WDTWK  = 4'b0100,
		RCR_EV_INTWK  = 4'b0101,
		RCR_EV_PIN    = 4'b0110,
		RCR_EV_PINSLP = 4'b0111,
		RCR_EV_INSTR  = 4'b1000,
		RCR_EV_OVF    = 4'b1001,
		RCR_EV_UNF    = 4'b1010,
		RCR_EV_WINV   = 4'b1011
	} rcr_event_t;

	typedef enum logic [1:0] {
		RCR_PC_HOLD  = 2'b00,
		RCR_PC_ZERO  = 2'b01,
		RCR_PC_NEXT  = 2'b10,
		RCR_PC_VECT  = 2'b11
	} rcr_pc_act_t;
endpackage

/* File: core/rcr_event_prio.sv */
`include "rcr_defines.svh"

// Picks one reset or wake source per cycle and classifies it by sleep state
module rcr_event_prio
	import rcr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       por_req,
	input  wire logic       bor_req,
	input  wire logic       wdt_req,
	input  wire logic       winv_req,
	input  wire logic       pin_req,
	input  wire logic       instr_req,
	input  wire logic       ovf_req,
	input  wire logic       unf_req,
	input  wire logic       int_req,
	input  wire logic       asleep,
	input  wire logic       stack_error_reset_enable,
	output rcr_event_t      evt
);
	rcr_event_t next_evt;

	// Power faults outrank everything; stack errors only count when enabled
	always_comb begin
		next_evt = RCR_EV_NONE;
		if (por_req)
			next_evt = RCR_EV_POR;
		else if (bor_req)
			next_evt = RCR_EV_BOR;
		else if (pin_req)
			next_evt = asleep ? RCR_EV_PINSLP : RCR_EV_PIN;
		else if (winv_req && !asleep)
			next_evt = RCR_EV_WINV;
		else if (wdt_req)
			next_evt = asleep ? RCR_EV_WDTWK : RCR_EV_WDT;
		else if (asleep && int_req)
			next_evt = RCR_EV_INTWK;
		else if (!asleep && ovf_req && stack_error_reset_enable)
			next_evt = RCR_EV_OVF;
		else if (!asleep && unf_req && stack_error_reset_enable)
			next_evt = RCR_EV_UNF;
		else if (!asleep && instr_req)
			next_evt = RCR_EV_INSTR;
	end

	always_ff @(posedge clk) begin
		if (srst)
			evt <= RCR_EV_NONE;
		else
			evt <= next_evt;
	end
endmodule // rcr_event_prio

/* File: core/rcr_top.sv */
// Decided for this implementation: the APB interface to the registers and the address map.
`include "rcr_defines.svh"

// Notes on behaviour
// (R1) Every reset or wake updates cause flags in status and power control
// (R2) Power-on: pc zero, timeout and power-down set, power-control power-on pattern
// (R3) Brown-out: stack flags and brown-out cleared, pin/instr/timeout/pd set
// (R4) Watchdog reset running: clear watchdog flag and timeout, restart at zero
// (R5) Watchdog wake from sleep: clear timeout and power-down, continue at next address
// (R6) Interrupt wake: set timeout, clear power-down, next address; vector if enabled
// (R7) Pin reset running: clear pin flag only, restart at zero
// (R8) Pin reset asleep: clear pin and power-down, set timeout, restart zero
// (R9) Reset instruction: clear instruction flag only, restart at zero
// (R10) Overflow with stack reset enabled: restart zero, set overflow flag
// (R11) Underflow with stack reset enabled: restart zero, set underflow flag
// (R12) Window violation: restart zero, clear timeout, window and watchdog flags
// (R13) Unimplemented bits of cause registers always read zero
// (R14) Power-on never leaves timeout or power-down cleared
// (R15) Software rewrites cause flags to inactive values after reading
module rcr_top
	import rcr_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        SRST,
	input  wire logic        POR_EVT,
	input  wire logic        BOR_EVT,
	input  wire logic        WDT_EVT,
	input  wire logic        WINV_EVT,
	input  wire logic        PIN_EVT,
	input  wire logic        INSTR_EVT,
	input  wire logic        OVF_EVT,
	input  wire logic        UNF_EVT,
	input  wire logic        INT_EVT,
	input  wire logic        ASLEEP,
	input  wire logic [15:0] PC_CUR,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             PC_LOAD,
	output logic      [15:0] PC_VALUE,
	output logic             PUSH_RET,
	output logic             IRQ
);
	logic [4:0]  status;
	logic [7:0]  pcon;
	logic [1:0]  ctrl;
	logic [`RCR_EVT_W-1:0] evt_stat;
	logic [`RCR_EVT_W-1:0] evt_en;
	logic        pc_load;
	logic [15:0] pc_value;
	logic        push_ret;
	logic [31:0] prdata;
	logic        pin_s1;
	logic        pin_s2;
	logic        pin_q;

	logic [4:0]  next_status;
	logic [7:0]  next_pcon;
	logic [1:0]  next_ctrl;
	logic [`RCR_EVT_W-1:0] next_evt_stat;
	logic [`RCR_EVT_W-1:0] next_evt_en;
	logic        next_pc_load;
	logic [15:0] next_pc_value;
	logic        next_push_ret;
	logic [31:0] next_prdata;
	logic        pin_edge;
	rcr_event_t  evt;
	rcr_pc_act_t pc_act;

	wire logic wr_en = PSEL && PENABLE && PWRITE;
	wire logic rd_en = PSEL && !PENABLE && !PWRITE;

	function automatic logic known_addr(input logic [11:0] a);
		known_addr = (a == `RCR_ADDR_STATUS) || (a == `RCR_ADDR_PCON) ||
			(a == `RCR_ADDR_CTRL) || (a == `RCR_ADDR_PC) ||
			(a == `RCR_ADDR_EVT_STAT) || (a == `RCR_ADDR_EVT_EN) ||
			(a == `RCR_ADDR_EVT_CLR);
	endfunction

	// Only the low byte lane carries these narrow registers
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
			input logic [3:0] s);
		lane0 = s[0] ? d[7:0] : old;
	endfunction

	// The reset pin is asynchronous, so it is synchronised before the edge detect
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_q  <= 1'b0;
		end else begin
			pin_s1 <= PIN_EVT;
			pin_s2 <= pin_s1;
			pin_q  <= pin_s2;
		end
	end
	assign pin_edge = pin_s2 && !pin_q;

	rcr_event_prio u_prio (
		.clk       (CLK_SYS),
		.srst      (SRST),
		.por_req   (POR_EVT),
		.bor_req   (BOR_EVT),
		.wdt_req   (WDT_EVT),
		.winv_req  (WINV_EVT),
		.pin_req   (pin_edge),
		.instr_req (INSTR_EVT),
		.ovf_req   (OVF_EVT),
		.unf_req   (UNF_EVT),
		.int_req   (INT_EVT),
		.asleep    (ASLEEP),
		.stack_error_reset_enable    (ctrl[`RCR_CTRL_STACK_ERROR_RESET_ENABLE]),
		.evt       (evt)
	);

	always_comb begin
		next_status   = status;
		next_pcon     = pcon;
		next_ctrl     = ctrl;
		next_evt_en   = evt_en;
		next_evt_stat = evt_stat;
		pc_act        = RCR_PC_HOLD;

		// Software writes go first so a same-cycle hardware event overrides them
		if (wr_en) begin
			case (PADDR)
				`RCR_ADDR_STATUS: next_status = 5'(lane0({3'h0, status}, PWDATA, PSTRB));
				`RCR_ADDR_PCON:   next_pcon = lane0(pcon, PWDATA, PSTRB)
					& `RCR_PC_WR_MASK; // [R15]
				`RCR_ADDR_CTRL:   next_ctrl = 2'(lane0({6'h0, ctrl}, PWDATA, PSTRB));
				`RCR_ADDR_EVT_EN: next_evt_en = PSTRB[0] ? PWDATA[`RCR_EVT_W-1:0] : evt_en;
				`RCR_ADDR_EVT_CLR: next_evt_stat = evt_stat
					& ~(PSTRB[0] ? PWDATA[`RCR_EVT_W-1:0] : {`RCR_EVT_W{1'b0}});
				default: ;
			endcase
		end

		case (evt) // [R1]
			RCR_EV_POR: begin
				next_status = `RCR_ST_POR_VAL; // [R2] [R14]
				next_pcon   = `RCR_PC_POR_VAL; // [R2]
				pc_act      = RCR_PC_ZERO;
			end
			RCR_EV_BOR: begin
				next_status = `RCR_ST_POR_VAL; // [R3]
				next_pcon[`RCR_PC_STACK_OVERFLOW_FLAG] = 1'b0; // [R3]
				next_pcon[`RCR_PC_STACK_UNDERFLOW_FLAG] = 1'b0;
				next_pcon[`RCR_PC_PIN]    = 1'b1;
				next_pcon[`RCR_PC_INSTR]  = 1'b1;
				next_pcon[`RCR_PC_BROWN]  = 1'b0;
				pc_act = RCR_PC_ZERO;
			end
			RCR_EV_WDT: begin
				next_status[`RCR_ST_TO] = 1'b0; // [R4]
				next_pcon[`RCR_PC_WDT]  = 1'b0;
				pc_act = RCR_PC_ZERO;
			end
			RCR_EV_WDTWK: begin
				next_status[`RCR_ST_TO] = 1'b0; // [R5]
				next_status[`RCR_ST_PD] = 1'b0;
				pc_act = RCR_PC_NEXT;
			end
			RCR_EV_INTWK: begin
				next_status[`RCR_ST_TO] = 1'b1; // [R6]
				next_status[`RCR_ST_PD] = 1'b0;
				pc_act = ctrl[`RCR_CTRL_GIE] ? RCR_PC_VECT : RCR_PC_NEXT;
			end
			RCR_EV_PIN: begin
				next_pcon[`RCR_PC_PIN] = 1'b0; // [R7]
				pc_act = RCR_PC_ZERO;
			end
			RCR_EV_PINSLP: begin
				next_pcon[`RCR_PC_PIN]  = 1'b0; // [R8]
				next_status[`RCR_ST_TO] = 1'b1;
				next_status[`RCR_ST_PD] = 1'b0;
				pc_act = RCR_PC_ZERO;
			end
			RCR_EV_INSTR: begin
				next_pcon[`RCR_PC_INSTR] = 1'b0; // [R9]
				pc_act = RCR_PC_ZERO;
			end
			RCR_EV_OVF: begin
				next_pcon[`RCR_PC_STACK_OVERFLOW_FLAG] = 1'b1; // [R10]
				pc_act = RCR_PC_ZERO;
			end
			RCR_EV_UNF: begin
				next_pcon[`RCR_PC_STACK_UNDERFLOW_FLAG] = 1'b1; // [R11]
				pc_act = RCR_PC_ZERO;
			end
			RCR_EV_WINV: begin
				next_status[`RCR_ST_TO]  = 1'b0; // [R12]
				next_pcon[`RCR_PC_WINV] = 1'b0;
				next_pcon[`RCR_PC_WDT]  = 1'b0;
				pc_act = RCR_PC_ZERO;
			end
			default: ;
		endcase

		// Status bit index equals event code minus one; set beats clear
		if (evt != RCR_EV_NONE)
			next_evt_stat[4'(evt - 4'd1)] = 1'b1;
	end

	always_comb begin
		next_push_ret = 1'b0;
		next_pc_load  = 1'b0;
		next_pc_value = pc_value;
		case (pc_act)
			RCR_PC_ZERO: begin
				next_pc_load  = 1'b1;
				next_pc_value = `RCR_RESET_VECTOR;
			end
			RCR_PC_NEXT: begin
				next_pc_load  = 1'b1;
				next_pc_value = PC_CUR + 16'h0001; // [R5] [R6]
			end
			RCR_PC_VECT: begin
				// Return address is pushed by the core from PC_CUR + 1
				next_pc_load  = 1'b1;
				next_push_ret = 1'b1;
				next_pc_value = `RCR_INT_VECTOR; // [R6]
			end
			default: ;
		endcase
	end

	always_comb begin
		next_prdata = prdata;
		if (rd_en) begin
			case (PADDR)
				`RCR_ADDR_STATUS:   next_prdata = {27'h0, status}; // [R13]
				`RCR_ADDR_PCON:     next_prdata = {24'h0, pcon & `RCR_PC_IMPL_MASK};
				`RCR_ADDR_CTRL:     next_prdata = {30'h0, ctrl};
				`RCR_ADDR_PC:       next_prdata = {16'h0, pc_value};
				`RCR_ADDR_EVT_STAT: next_prdata = {21'h0, evt_stat};
				`RCR_ADDR_EVT_EN:   next_prdata = {21'h0, evt_en};
				default:            next_prdata = 32'h0;
			endcase
		end
	end

	// Power-on values also apply under SRST so timeout and power-down never start cleared
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			status   <= `RCR_ST_POR_VAL; // [R14]
			pcon     <= `RCR_PC_POR_VAL;
			ctrl     <= 2'h0;
			evt_stat <= '0;
			evt_en   <= '0;
			pc_load  <= 1'b0;
			pc_value <= `RCR_RESET_VECTOR;
			push_ret <= 1'b0;
			prdata   <= 32'h0;
		end else begin
			status   <= next_status;
			pcon     <= next_pcon;
			ctrl     <= next_ctrl;
			evt_stat <= next_evt_stat;
			evt_en   <= next_evt_en;
			pc_load  <= next_pc_load;
			pc_value <= next_pc_value;
			push_ret <= next_push_ret;
			prdata   <= next_prdata;
		end
	end

	assign PRDATA   = prdata;
	assign PREADY   = 1'b1;
	assign PSLVERR  = PSEL && PENABLE && (!known_addr(PADDR) ||
		(!PWRITE && PADDR == `RCR_ADDR_EVT_CLR));
	assign PC_LOAD  = pc_load;
	assign PC_VALUE = pc_value;
	assign PUSH_RET = push_ret;
	assign IRQ      = |(evt_stat & evt_en);
endmodule // rcr_top

/* File: sim/rcr_assertions.sv */
module rcr_assertions
	import rcr_pkg::*;
(
	input wire logic        CLK_SYS,
	input wire logic        SRST,
	input wire logic        POR_EVT,
	input wire logic        BOR_EVT,
	input wire logic        WDT_EVT,
	input wire logic        WINV_EVT,
	input wire logic        PIN_EVT,
	input wire logic        INSTR_EVT,
	input wire logic        OVF_EVT,
	input wire logic        UNF_EVT,
	input wire logic        INT_EVT,
	input wire logic        ASLEEP,
	input wire logic [15:0] PC_CUR,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PSLVERR,
	input wire logic        PC_LOAD,
	input wire logic [15:0] PC_VALUE,
	input wire logic        PUSH_RET
);
	logic [7:0] pin_hist;
	logic       quiet;
	logic       cause;
	logic       rd_acc;
	// Pin path latency is hidden behind the synchroniser, so keep a wide history
	always_ff @(posedge CLK_SYS) pin_hist <= {pin_hist[6:0], PIN_EVT};
	assign quiet = !PIN_EVT && pin_hist == 8'h00 && !POR_EVT && !BOR_EVT;
	assign cause = POR_EVT || BOR_EVT || WDT_EVT || WINV_EVT || INSTR_EVT || OVF_EVT
		|| UNF_EVT || INT_EVT;
	assign rd_acc = PSEL && PENABLE && !PWRITE;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	sequence s_zero;
		##2 PC_LOAD && PC_VALUE == 16'h0000;
	endsequence
	sequence s_next;
		##2 PC_LOAD && PC_VALUE == $past(PC_CUR, 2) + 16'h0001;
	endsequence
	a_zero_restart: assert property (
		(POR_EVT || BOR_EVT || !ASLEEP && (WDT_EVT || WINV_EVT || INSTR_EVT)) |-> s_zero)
		else $error("restart not at zero");
	a_wdt_wake: assert property (ASLEEP && WDT_EVT && quiet |-> s_next)
		else $error("watchdog wake not at next address");
	a_int_wake: assert property (ASLEEP && INT_EVT && !WDT_EVT && quiet |->
		##2 PC_LOAD && (PUSH_RET ? PC_VALUE == 16'h0004 : PC_VALUE == $past(PC_CUR, 2) + 16'h0001))
		else $error("interrupt wake address wrong");
	a_push_vector: assert property (PUSH_RET |-> PC_LOAD && PC_VALUE == 16'h0004)
		else $error("push without vector load");
	a_load_cause: assert property (PC_LOAD |-> pin_hist != 8'h00 || $past(cause, 2))
		else $error("load without cause");
	a_upper_zero: assert property (rd_acc && PADDR[11:3] == 9'h0 && PADDR[1:0] == 2'h0 |->
		PRDATA[31:8] == 24'h0 && (PADDR[2] || PRDATA[7:5] == 3'h0))
		else $error("unused bits not zero");
	a_err_map: assert property (PSEL && PENABLE && PADDR[1:0] == 2'h0 |->
		PSLVERR == (PADDR > 12'h018 || PADDR == 12'h018 && !PWRITE))
		else $error("error response wrong");
	a_err_zero: assert property (rd_acc && PSLVERR |-> PRDATA == 32'h0)
		else $error("refused read not zero");
endmodule // rcr_assertions

/* File: sim/rcr_top_tb.sv */
module rcr_top_tb
	import rcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		rcr_event_t  e;
		logic        s;
		logic [1:0]  c;
		logic [7:0]  pi;
		logic [7:0]  pe;
		logic [1:0]  st;
		rcr_pc_act_t a;
	} rcr_row_t;
	// Event, asleep, {irq en, stack en}, flags before, after, {timeout, power-down}
	// Order matters: the test never writes status, so each row starts where the last ended
	rcr_row_t rows [13] = '{
		'{RCR_EV_WDT, 0, 0, 8'hff, 8'hef, 2'b01, RCR_PC_ZERO},
		'{RCR_EV_WDTWK, 1, 0, 8'h5a, 8'h5a, 2'b00, RCR_PC_NEXT},
		'{RCR_EV_PINSLP, 1, 0, 8'h0f, 8'h07, 2'b10, RCR_PC_ZERO},
		'{RCR_EV_WDTWK, 1, 0, 8'h33, 8'h33, 2'b00, RCR_PC_NEXT},
		'{RCR_EV_INTWK, 1, 0, 8'ha5, 8'ha5, 2'b10, RCR_PC_NEXT},
		'{RCR_EV_WDTWK, 1, 0, 8'h00, 8'h00, 2'b00, RCR_PC_NEXT},
		'{RCR_EV_INTWK, 1, 2, 8'h3c, 8'h3c, 2'b10, RCR_PC_VECT},
		'{RCR_EV_PIN, 0, 0, 8'hff, 8'hf7, 2'b10, RCR_PC_ZERO},
		'{RCR_EV_INSTR, 0, 0, 8'hff, 8'hfb, 2'b10, RCR_PC_ZERO},
		'{RCR_EV_OVF, 0, 1, 8'h00, 8'h80, 2'b10, RCR_PC_ZERO},
		'{RCR_EV_UNF, 0, 1, 8'h00, 8'h40, 2'b10, RCR_PC_ZERO},
		'{RCR_EV_WINV, 0, 0, 8'hff, 8'hcf, 2'b00, RCR_PC_ZERO},
		'{RCR_EV_BOR, 0, 0, 8'hd3, 8'h1e, 2'b11, RCR_PC_ZERO}
	};
	logic [3:0]  idx [12] = '{0, 0, 1, 2, 2, 8, 4, 4, 5, 6, 7, 3};
	logic        clk, srst, asleep, psel, pen, pwr, err, ld, psh;
	logic        pready, pslverr, pc_load, push_ret, irq;
	logic [8:0]  ev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] pc_value, pcv, pcc;
	rcr_row_t    r;
	int          errors, compares;
	rcr_top uut (
		.CLK_SYS(clk), .SRST(srst), .POR_EVT(ev[0]), .BOR_EVT(ev[1]), .WDT_EVT(ev[2]),
		.WINV_EVT(ev[3]), .PIN_EVT(ev[4]), .INSTR_EVT(ev[5]), .OVF_EVT(ev[6]),
		.UNF_EVT(ev[7]), .INT_EVT(ev[8]), .ASLEEP(asleep), .PC_CUR(pcc),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PC_LOAD(pc_load), .PC_VALUE(pc_value), .PUSH_RET(push_ret), .IRQ(irq));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) pen <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task ci(input logic e);
		@(negedge clk);
		chk(irq, e);
	endtask
	// Window of ten edges covers the pin synchroniser plus the two-stage answer
	task fire(input rcr_event_t e, input logic s);
		@(posedge clk) asleep <= s;
		@(posedge clk) ev[idx[e]] <= 1'b1;
		@(posedge clk) ev <= '0;
		ld = 1'b0;
		psh = 1'b0;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			if (pc_load === 1'b1) begin
				ld = 1'b1;
				pcv = pc_value;
				psh = push_ret;
			end
		end
		asleep <= 1'b0;
	endtask
	task results;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		results();
	end
	initial begin
		srst = 1'b1;
		{ev, asleep, psel, pen, pwr, paddr, pwdata} = '0;
		pcc = 16'h1234;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(12'h000, 32'h18);
		foreach (rows[i]) begin
			r = rows[i];
			pcc <= pcc + 16'h0101;
			apb(1'b1, 12'h008, {30'h0, r.c});
			apb(1'b1, 12'h004, {24'h0, r.pi});
			fire(r.e, r.s);
			chk(ld, 1'b1);
			chk(pcv, r.a == RCR_PC_ZERO ? 16'h0 : r.a == RCR_PC_NEXT ? pcc + 16'h0001 : 16'h4);
			chk(psh, r.a == RCR_PC_VECT);
			rd(12'h004, {24'h0, r.pe});
			rd(12'h000, {27'h0, r.st, 3'h0});
		end
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h004, 32'h0);
		fire(RCR_EV_OVF, 1'b0);
		chk(ld, 1'b0);
		rd(12'h004, 32'h0);
		apb(1'b1, 12'h004, 32'hff);
		fire(RCR_EV_POR, 1'b0);
		chk(pcv, 32'h0);
		rd(12'h000, 32'h18);
		rd(12'h004, 32'h1c);
		chk(q[7:6], 2'b00);
		rd(12'h010, 32'h7ff);
		apb(1'b1, 12'h014, 32'h0);
		apb(1'b1, 12'h018, 32'h7ff);
		ci(1'b0);
		rd(12'h010, 32'h0);
		apb(1'b1, 12'h014, 32'h4);
		fire(RCR_EV_WDT, 1'b0);
		ci(1'b1);
		rd(12'h010, 32'h4);
		apb(1'b1, 12'h014, 32'h0);
		ci(1'b0);
		apb(1'b1, 12'h014, 32'h4);
		ci(1'b1);
		apb(1'b1, 12'h018, 32'h4);
		ci(1'b0);
		fire(RCR_EV_WDT, 1'b0);
		ci(1'b1);
		@(posedge clk) srst <= 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		ci(1'b0);
		rd(12'h000, 32'h18);
		rd(12'h004, 32'h1c);
		rd(12'h01c, 32'h0);
		chk(err, 1'b1);
		rd(12'h018, 32'h0);
		chk(err, 1'b1);
		results();
	end
endmodule // rcr_top_tb

bind rcr_top rcr_assertions u_chk (.*);
